// ===== hw/sdq_descriptor.sv
// Queue descriptor store and write-pointer engine for 128 SDRAM queues,
// with the cell-request FIFO in front of it.
// Assumes register strobes and cell requests come from the core clock.
//
// Functional notes
// - The 128 descriptors occupy 2000h to 2FFEh, one structure per queue.
// - Word at offset 00h holds start cell address bits 24:9.
// - Offset 02h bits 15:13 hold start bits 8:6; bits 12:0 read zero.
// - End cell address uses offsets 04h and 06h in the same way.
// - Queue capacity is end minus start plus one cells.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps

module sdq_fifo #(
  parameter int WIDTH = 7,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("FIFO depth must be a power of two, at least two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;

  wire full  = (wr_ptr[AW] != rd_ptr[AW]) &&
               (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire empty = (wr_ptr == rd_ptr);
  wire push  = in_valid_i && !full;
  wire pop   = out_ready_i && !empty;

  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= wr_ptr + (AW+1)'(push);
      rd_ptr <= rd_ptr + (AW+1)'(pop);
    end
  end
endmodule

module sdq_descriptor #(
  parameter int FIFO_DEPTH = sdq_pkg::FIFO_DEPTH
) (
  input  wire logic                      sys_clk_i,
  input  wire logic                      rst_i,
  input  wire logic [15:0]               reg_addr_i,
  input  wire logic [15:0]               reg_wdata_i,
  input  wire logic                      reg_wr_i,
  input  wire logic                      reg_rd_i,
  output logic [15:0]                    reg_rdata_o,
  input  wire logic                      cell_valid_i,
  input  wire sdq_pkg::sdq_cell_req_type cell_req_i,
  output logic                           cell_ready_o,
  output logic                           sdram_valid_o,
  output sdq_pkg::sdq_sdram_req_type     sdram_req_o,
  input  wire logic                      sdram_ready_i,
  output logic                           cell_drop_o
);
  localparam int AW = sdq_pkg::CELL_AW;
  localparam int QW = sdq_pkg::QUEUE_W;
  localparam int LW = sdq_pkg::LOW_W;

  if (FIFO_DEPTH < 2) begin : g_bad_param
    $error("FIFO depth too small");
  end

  // Descriptor storage; contents are undefined until software loads them
  logic [AW-1:0] start_mem [sdq_pkg::NUM_QUEUES];
  logic [AW-1:0] end_mem   [sdq_pkg::NUM_QUEUES];
  logic [AW-1:0] wptr_mem  [sdq_pkg::NUM_QUEUES];
  logic [sdq_pkg::NUM_QUEUES-1:0] wr_en;

  // Register decode
  wire          desc_hit = (reg_addr_i >= sdq_pkg::DESC_LO) &&
                           (reg_addr_i <= sdq_pkg::DESC_HI);
  wire [QW-1:0] desc_q   = reg_addr_i[sdq_pkg::DESC_Q_LSB +: QW];
  wire [4:0]    desc_ofs = reg_addr_i[4:0];
  wire [15:0]   ctrl_ofs = reg_addr_i - sdq_pkg::CTRL_LO;
  wire          ctrl_hit = (reg_addr_i >= sdq_pkg::CTRL_LO) &&
                           (reg_addr_i <= sdq_pkg::CTRL_HI);
  wire [QW-1:0] ctrl_q   = ctrl_ofs[QW:1];
  wire          dwr      = reg_wr_i && desc_hit;
  wire [LW-1:0] wlow     = reg_wdata_i[sdq_pkg::LOW_MSB:sdq_pkg::LOW_LSB];

  wire wr_start_hi = dwr && desc_ofs == sdq_pkg::OFS_START_HI;
  wire wr_start_lo = dwr && desc_ofs == sdq_pkg::OFS_START_LO;
  wire wr_end_hi   = dwr && desc_ofs == sdq_pkg::OFS_END_HI;
  wire wr_end_lo   = dwr && desc_ofs == sdq_pkg::OFS_END_LO;
  wire wr_wptr_hi  = dwr && desc_ofs == sdq_pkg::OFS_WPTR_HI;
  wire wr_wptr_lo  = dwr && desc_ofs == sdq_pkg::OFS_WPTR_LO;

  // Cell request path
  sdq_pkg::sdq_cell_req_type fifo_req;
  logic                      fifo_valid;
  wire out_free = !sdram_valid_o || sdram_ready_i;
  wire take     = fifo_valid && out_free;

  sdq_fifo #(
    .WIDTH ($bits(sdq_pkg::sdq_cell_req_type)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (cell_valid_i),
    .in_ready_o  (cell_ready_o),
    .in_data_i   (cell_req_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (out_free),
    .out_data_o  (fifo_req)
  );

  wire [QW-1:0] cur_q     = fifo_req.queue;
  wire          cur_en    = wr_en[cur_q];
  wire [AW-1:0] cur_start = start_mem[cur_q];
  wire [AW-1:0] cur_end   = end_mem[cur_q];
  wire [AW-1:0] cur_ptr   = wptr_mem[cur_q];
  wire          at_end    = (cur_ptr == cur_end);
  wire [AW-1:0] next_ptr  = at_end ? cur_start
                                   : cur_ptr + sdq_pkg::CELL_ONE;
  wire          advance   = take && cur_en;

  // Start and end words: high word is bits 24:9, low word bits 8:6
  always_ff @(posedge sys_clk_i) begin
    if (wr_start_hi) begin
      start_mem[desc_q][AW-1:LW] <= reg_wdata_i;
    end
    if (wr_start_lo) begin
      start_mem[desc_q][LW-1:0] <= wlow;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (wr_end_hi) begin
      end_mem[desc_q][AW-1:LW] <= reg_wdata_i;
    end
    if (wr_end_lo) begin
      end_mem[desc_q][LW-1:0] <= wlow;
    end
  end

  // Software load wins only on its own queue; others keep stepping
  wire sw_same = (wr_wptr_hi || wr_wptr_lo) && (desc_q == cur_q);
  wire hw_step = advance && !sw_same;

  always_ff @(posedge sys_clk_i) begin
    if (wr_wptr_hi) begin
      wptr_mem[desc_q][AW-1:LW] <= reg_wdata_i;
    end
    if (wr_wptr_lo) begin
      wptr_mem[desc_q][LW-1:0] <= wlow;
    end
    if (hw_step) begin
      wptr_mem[cur_q] <= next_ptr;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_en <= '0;
    end else if (reg_wr_i && ctrl_hit) begin
      wr_en[ctrl_q] <= reg_wdata_i[sdq_pkg::CTRL_WR_EN];
    end
  end

  // Read mux; capacity counts both end cells
  wire [AW-1:0] sel_start = start_mem[desc_q];
  wire [AW-1:0] sel_end   = end_mem[desc_q];
  wire [AW-1:0] sel_ptr   = wptr_mem[desc_q];
  wire [AW-1:0] sel_cap   = sel_end - sel_start + sdq_pkg::CELL_ONE;
  wire [15:0] desc_rd =
    (desc_ofs == sdq_pkg::OFS_START_HI) ? sel_start[AW-1:LW] :
    (desc_ofs == sdq_pkg::OFS_START_LO) ?
      {sel_start[LW-1:0], sdq_pkg::LOW_PAD} :
    (desc_ofs == sdq_pkg::OFS_END_HI)   ? sel_end[AW-1:LW] :
    (desc_ofs == sdq_pkg::OFS_END_LO)   ?
      {sel_end[LW-1:0], sdq_pkg::LOW_PAD} :
    (desc_ofs == sdq_pkg::OFS_WPTR_HI)  ? sel_ptr[AW-1:LW] :
    (desc_ofs == sdq_pkg::OFS_WPTR_LO)  ?
      {sel_ptr[LW-1:0], sdq_pkg::LOW_PAD} :
    (desc_ofs == sdq_pkg::OFS_CAP_HI)   ? sel_cap[AW-1:LW] :
    (desc_ofs == sdq_pkg::OFS_CAP_LO)   ?
      {sel_cap[LW-1:0], sdq_pkg::LOW_PAD} : 16'h0000;
  wire [15:0] ctrl_rd = {14'h0000, wr_en[ctrl_q], 1'b0};
  wire [15:0] rd_value = desc_hit ? desc_rd :
                         ctrl_hit ? ctrl_rd : 16'h0000;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 16'h0000;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_value : 16'h0000;
    end
  end

  // Disabled queues swallow their cells and flag the drop
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sdram_valid_o <= 1'b0;
      sdram_req_o   <= '0;
      cell_drop_o   <= 1'b0;
    end else begin
      cell_drop_o <= take && !cur_en;
      if (advance) begin
        sdram_valid_o <= 1'b1;
        sdram_req_o   <= '{cell_addr: cur_ptr, queue: cur_q};
      end else if (sdram_ready_i) begin
        sdram_valid_o <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  region_bounds_a: assert property (
    (reg_rd_i && !desc_hit && !ctrl_hit) |=> reg_rdata_o == 16'h0000)
    else $error("read outside mapped regions returned data");

  start_high_a: assert property (
    (reg_rd_i && $past(wr_start_hi) && $past(reg_addr_i) == reg_addr_i)
    |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("start high word did not read back");

  low_reserved_a: assert property (
    (reg_rd_i && desc_hit && desc_ofs[1])
    |=> reg_rdata_o[12:0] == 13'h0000)
    else $error("reserved low-word bits not zero");

  end_low_a: assert property (
    (reg_rd_i && $past(wr_end_lo) && $past(reg_addr_i) == reg_addr_i)
    |=> reg_rdata_o[15:13] == $past(reg_wdata_i[15:13], 2))
    else $error("end low bits did not read back");

  capacity_a: assert property (
    (reg_rd_i && desc_hit && desc_ofs == sdq_pkg::OFS_CAP_LO)
    |=> reg_rdata_o[15:13] == $past(sel_end[2:0] - sel_start[2:0] + 3'h1))
    else $error("capacity low bits wrong");

  wrap_start_a: assert property (
    (advance && at_end && !dwr)
    |=> wptr_mem[$past(cur_q)] == $past(cur_start))
    else $error("write pointer did not wrap to start");

  step_one_a: assert property (
    (advance && !at_end && !dwr)
    |=> wptr_mem[$past(cur_q)] == $past(cur_ptr) + sdq_pkg::CELL_ONE)
    else $error("write pointer did not step by one cell");

  issue_addr_a: assert property (
    advance |=> sdram_valid_o && sdram_req_o.cell_addr == $past(cur_ptr))
    else $error("issued address is not the write pointer");

  start_low_a: assert property (
    (reg_rd_i && $past(wr_start_lo) && $past(reg_addr_i) == reg_addr_i)
    |=> reg_rdata_o[15:13] == $past(reg_wdata_i[15:13], 2))
    else $error("start low bits did not read back");

  end_high_a: assert property (
    (reg_rd_i && $past(wr_end_hi) && $past(reg_addr_i) == reg_addr_i)
    |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("end high word did not read back");

  req_hold_a: assert property (
    (sdram_valid_o && !sdram_ready_i)
    |=> sdram_valid_o && $stable(sdram_req_o))
    else $error("held request changed before acceptance");

  drop_pulse_a: assert property (
    (take && !cur_en) |=> cell_drop_o)
    else $error("cell for disabled queue not flagged");

  enable_readback_a: assert property (
    (reg_rd_i && ctrl_hit && $past(reg_wr_i && ctrl_hit) &&
     $past(ctrl_q) == ctrl_q)
    |=> reg_rdata_o[1] == $past(reg_wdata_i[sdq_pkg::CTRL_WR_EN], 2))
    else $error("write enable did not read back");

  wrap_seen_c: cover property (advance && at_end);
  fifo_full_c: cover property (!cell_ready_o && cell_valid_i);
  drop_seen_c: cover property (cell_drop_o);
  stall_c:     cover property (sdram_valid_o && !sdram_ready_i [*3]);
endmodule

// ===== hw/sdq_pkg.sv
// Constants and carrier types for the egress queue descriptor block.
// Assumes a 16-bit register port with byte addresses and one core clock.
package sdq_pkg;
  localparam int NUM_QUEUES = 128;
  localparam int QUEUE_W    = 7;
  localparam int CELL_AW    = 19;   // Cell address, byte bits 24:6
  localparam int LOW_W      = 3;    // Cell address bits 8:6
  localparam int REG_AW     = 16;
  localparam int REG_DW     = 16;
  localparam int FIFO_DEPTH = 8;

  // Descriptor region, one 32-byte structure per queue
  localparam logic [15:0] DESC_LO   = 16'h2000;
  localparam logic [15:0] DESC_HI   = 16'h2FFE;
  localparam int          DESC_Q_LSB = 5;

  // Byte offsets inside one descriptor structure
  localparam logic [4:0] OFS_START_HI = 5'h00;
  localparam logic [4:0] OFS_START_LO = 5'h02;
  localparam logic [4:0] OFS_END_HI   = 5'h04;
  localparam logic [4:0] OFS_END_LO   = 5'h06;
  localparam logic [4:0] OFS_WPTR_HI  = 5'h08;
  localparam logic [4:0] OFS_WPTR_LO  = 5'h0A;
  localparam logic [4:0] OFS_CAP_HI   = 5'h18;
  localparam logic [4:0] OFS_CAP_LO   = 5'h1A;

  // Per-queue control words, one 16-bit word per queue
  localparam logic [15:0] CTRL_LO     = 16'h0440;
  localparam logic [15:0] CTRL_HI     = 16'h053E;
  localparam int          CTRL_WR_EN  = 1;

  // Low words carry address bits 8:6 in bits 15:13, rest reads zero
  localparam int LOW_MSB = 15;
  localparam int LOW_LSB = 13;
  localparam logic [12:0] LOW_PAD = 13'h0000;
  localparam logic [CELL_AW-1:0] CELL_ONE = 19'h0_0001;

  typedef struct packed {
    logic [QUEUE_W-1:0] queue;
  } sdq_cell_req_type;

  typedef struct packed {
    logic [CELL_AW-1:0] cell_addr;
    logic [QUEUE_W-1:0] queue;
  } sdq_sdram_req_type;
endpackage

// ===== verification/sdq_sdram_model.sv
// SDRAM write side as seen by the queue descriptor block.
// Assumes one core clock; the bench steers stall and slow pacing.
`timescale 1ns/1ps

module sdq_sdram_model (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic stall_i,
  input  wire logic slow_i,
  output logic      ready_o
);
  // Slow pacing accepts every other cycle, like a busy bank
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ready_o <= 1'b0;
    end else begin
      ready_o <= !stall_i && (!slow_i || !ready_o);
    end
  end
endmodule

// ===== verification/test_sdram_queue_descriptor.sv
// Self-checking bench for the queue descriptor block and its cell path.
// Assumes the SDRAM partner model and the design files are compiled first.
`timescale 1ns/1ps

module test_sdram_queue_descriptor;
  localparam int          DEPTH = 8;
  localparam logic [18:0] S3    = 19'h0_1236;
  localparam logic [18:0] E3    = 19'h0_1239;
  localparam logic [15:0] D3    = 16'h2060;
  logic                          sys_clk_i;
  logic                          rst_i;
  logic [15:0]                   reg_addr_i;
  logic [15:0]                   reg_wdata_i;
  logic                          reg_wr_i;
  logic                          reg_rd_i;
  logic [15:0]                   reg_rdata_o;
  logic                          cell_valid_i;
  sdq_pkg::sdq_cell_req_type     cell_req_i;
  logic                          cell_ready_o;
  logic                          sdram_valid_o;
  sdq_pkg::sdq_sdram_req_type    sdram_req_o;
  logic                          sdram_ready_i;
  logic                          cell_drop_o;
  logic                          stall;
  logic                          slow;
  int                            failures;
  int                            n_tests;
  int                            cycles;
  int                            drops;
  logic [18:0]                   wp;
  logic [18:0]                   exp_q[$];
  // Address, write data, expected read-back
  logic [47:0] rows [9] = '{
    {16'h2000, 16'hABCD, 16'hABCD}, {16'h2002, 16'hFFFF, 16'hE000},
    {16'h2FE4, 16'h1234, 16'h1234}, {16'h2FE6, 16'h5FFF, 16'h4000},
    {16'h2FEA, 16'hBFFF, 16'hA000}, {16'h200C, 16'hFFFF, 16'h0000},
    {16'h2FFE, 16'hFFFF, 16'h0000}, {16'h3000, 16'hFFFF, 16'h0000},
    {16'h0452, 16'hFFFF, 16'h0002}};

  sdq_descriptor #(.FIFO_DEPTH(DEPTH)) sdq_descriptor_inst (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .cell_valid_i(cell_valid_i),
    .cell_req_i(cell_req_i), .cell_ready_o(cell_ready_o),
    .sdram_valid_o(sdram_valid_o), .sdram_req_o(sdram_req_o),
    .sdram_ready_i(sdram_ready_i), .cell_drop_o(cell_drop_o));

  sdq_sdram_model sdq_sdram_model_inst (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .stall_i(stall),
    .slow_i(slow), .ready_o(sdram_ready_i));

  task automatic test_done();
    if (failures == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [18:0] exp,
                       input logic [18:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i    <= 1'b0;
  endtask

  task automatic reg_rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i   <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask

  task automatic set_addr(input logic [15:0] a, input logic [18:0] v);
    reg_wr(a, v[18:3]);
    reg_wr(a + 16'h0002, {v[2:0], 13'h0000});
  endtask

  task automatic get_addr(input logic [15:0] a, output logic [18:0] v);
    logic [15:0] h;
    logic [15:0] l;
    reg_rd(a, h);
    reg_rd(a + 16'h0002, l);
    v = {h, l[15:13]};
  endtask

  // Valid is held until taken or until a refusal has lasted 20 cycles
  task automatic push(input logic [6:0] q, output logic taken);
    taken = 1'b0;
    @(posedge sys_clk_i);
    cell_valid_i     <= 1'b1;
    cell_req_i.queue <= q;
    for (int k = 0; k < 20 && !taken; k++) begin
      @(posedge sys_clk_i);
      taken = cell_ready_o;
    end
    cell_valid_i <= 1'b0;
    if (taken && q == 7'h03) begin
      exp_q.push_back(wp);
      wp = (wp == E3) ? S3 : wp + 19'h0_0001;
    end
  endtask

  task automatic drain();
    for (int k = 0; k < 300 && exp_q.size() != 0; k++)
      @(posedge sys_clk_i);
    check("requests left", 19'h0_0000, 19'(exp_q.size()));
  endtask

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i) begin
    logic [18:0] e;
    cycles++;
    if (!rst_i && sdram_valid_o === 1'b1 && sdram_ready_i === 1'b1) begin
      e = (exp_q.size() != 0) ? exp_q.pop_front() : 19'bx;
      check("sdram cell address", e, sdram_req_o.cell_addr);
      check("sdram queue", 19'h0_0003, 19'(sdram_req_o.queue));
    end
    if (!rst_i && cell_drop_o === 1'b1)
      drops++;
    if (cycles > 20000) begin
      failures++;
      test_done();
    end
  end

  initial begin
    logic [15:0] d;
    logic [18:0] v;
    logic        t;
    int          n;
    {reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i} = '0;
    {cell_valid_i, stall, slow} = '0;
    cell_req_i = '0;
    rst_i = 1'b1;
    repeat (6) @(posedge sys_clk_i);
    check("reset ready", 19'h0_0001, 19'(cell_ready_o));
    check("reset valid", 19'h0_0000, 19'(sdram_valid_o));
    check("reset rdata", 19'h0_0000, 19'(reg_rdata_o));
    rst_i <= 1'b0;
    reg_rd(16'h0446, d);
    check("enable reset", 19'h0_0000, 19'(d));
    foreach (rows[i]) begin
      reg_wr(rows[i][47:32], rows[i][31:16]);
      reg_rd(rows[i][47:32], d);
      check("register", 19'(rows[i][15:0]), 19'(d));
    end
    reg_wr(16'h0452, 16'h0000);
    reg_wr(16'h0446, 16'h0000);
    set_addr(D3, S3);
    set_addr(D3 + 16'h0004, E3);
    set_addr(D3 + 16'h0008, S3);
    set_addr(D3 + 16'h000C, S3);
    get_addr(D3 + 16'h0018, v);
    check("capacity", E3 - S3 + 19'h0_0001, v);
    get_addr(D3 + 16'h0004, v);
    check("end address", E3, v);
    wp = S3;
    push(7'h04, t);
    repeat (4) @(posedge sys_clk_i);
    check("drop count", 19'h0_0001, 19'(drops));
    reg_wr(16'h0446, 16'h0002);
    slow <= 1'b1;
    // Six cells in a four-cell queue wrap past the end address
    for (int i = 0; i < 6; i++) begin
      push(7'h03, t);
      check("cell taken", 19'h0_0001, 19'(t));
    end
    drain();
    reg_wr(16'h0446, 16'h0000);
    get_addr(D3 + 16'h0008, v);
    check("write pointer", wp, v);
    reg_wr(16'h0446, 16'h0002);
    slow  <= 1'b0;
    stall <= 1'b1;
    n = 0;
    for (int i = 0; i < DEPTH + 4; i++) begin
      push(7'h03, t);
      if (!t)
        break;
      n++;
    end
    // One entry may already sit in the output register
    check("fifo fill", 19'h0_0001, 19'(n >= DEPTH && n <= DEPTH + 1));
    stall <= 1'b0;
    drain();
    check("drop count end", 19'h0_0001, 19'(drops));
    test_done();
  end
endmodule
